//--- src/ptc_pkg.sv
// Purpose: shared constants, types and helpers for the pass-through and remote control block
// Assumes: 16-bit words, 64-word host blocks
// Notes:   codes held as sized hex values
`default_nettype none
package ptc_pkg;

	// -------------------------------------------------------------
	// host block layout
	// -------------------------------------------------------------
	localparam int          BLOCK_WORDS   = 64;
	localparam logic [15:0] ID_PASS_GROUP = 16'h270C;  // 9996 family
	localparam logic [15:0] ID_COIL_ONE   = 16'h26E6;  // 9958
	localparam logic [15:0] ID_REG_INT    = 16'h26E4;  // 9956
	localparam logic [15:0] ID_REG_FLOAT  = 16'h26E5;  // 9957
	localparam logic [15:0] ID_COIL_MULTI = 16'h26E7;  // 9959
	localparam logic [5:0]  W_ZERO        = 6'h00;
	localparam logic [5:0]  W_ID          = 6'h01;
	localparam logic [5:0]  W_COUNT       = 6'h02;
	localparam logic [5:0]  W_ADDR        = 6'h03;
	localparam logic [5:0]  W_DATA        = 6'h04;
	localparam logic [5:0]  W_RAW_FIRST   = 6'h05;
	localparam logic [5:0]  W_RAW_LAST    = 6'h3A;   // word 58

	// -------------------------------------------------------------
	// remote command control register
	// -------------------------------------------------------------
	localparam logic [15:0] CTRL_ADDR     = 16'h1E78;  // holding address 47801
	localparam logic [15:0] CTRL_RESET    = 16'h0000;
	localparam logic [15:0] CMD_UPLOAD    = 16'h270D;  // 9997
	localparam logic [15:0] CMD_WARM      = 16'h270E;  // 9998
	localparam logic [15:0] CMD_COLD      = 16'h270F;  // 9999
	localparam logic [15:0] RES_OK        = 16'h0000;
	localparam logic [15:0] RES_GENERAL   = 16'hFFFF;  // -1
	localparam logic [15:0] RES_PORT1     = 16'hFFFE;  // -2
	localparam logic [15:0] RES_PORT2     = 16'hFFFD;  // -3

	// -------------------------------------------------------------
	// request decoding
	// -------------------------------------------------------------
	localparam logic [7:0]  FC_READ_HOLD  = 8'h03;
	localparam logic [7:0]  FC_COIL_ONE   = 8'h05;
	localparam logic [7:0]  FC_REG_ONE    = 8'h06;
	localparam logic [7:0]  FC_COIL_MULTI = 8'h0F;
	localparam logic [7:0]  FC_REG_MULTI  = 8'h10;
	localparam logic [1:0]  SWAP_PASS     = 2'h2;
	localparam logic [1:0]  SWAP_PASS_BS  = 2'h3;
	localparam logic [15:0] CNT_RESET     = 16'h0000;

	typedef enum logic [1:0] {
		CS_IDLE   = 2'b00,
		CS_UPLOAD = 2'b01
	} ctrl_state_e;

	// masked merge: unmasked bits keep their old value
	function automatic logic [15:0] mergeBits(input logic [15:0] old, input logic [15:0] nw,
		input logic [15:0] mask);
		mergeBits = (old & ~mask) | (nw & mask);
	endfunction

	function automatic logic [15:0] swapBytes(input logic [15:0] w);
		swapBytes = {w[7:0], w[15:8]};
	endfunction

	function automatic logic isWriteFunc(input logic [7:0] fc);
		isWriteFunc = (fc == FC_COIL_ONE) || (fc == FC_REG_ONE) ||
			(fc == FC_COIL_MULTI) || (fc == FC_REG_MULTI);
	endfunction

endpackage
`default_nettype wire

//--- src/req_chk_if.sv
// Purpose: carries a raw slave request to the qualifier and its verdict back
// Assumes: one request presented per cycle, verdict is combinational
// Notes:   core drives the request side, qualifier the verdict side
`timescale 1ns/1ps
`default_nettype none
interface req_chk_if #(parameter int DBW = 5);
	logic           valid;
	logic           isMaster;
	logic [7:0]     myNode;
	logic [15:0]    addrOffset;
	logic [7:0]     node;
	logic [7:0]     func;
	logic [15:0]    addr;
	logic [7:0]     count;
	logic           accept;
	logic           legal;
	logic           isCtrl;
	logic [DBW-1:0] dbWord;
	logic [3:0]     bitPos;
	logic [7:0]     nWords;

	modport core (output valid, isMaster, myNode, addrOffset, node, func, addr, count,
		input accept, legal, isCtrl, dbWord, bitPos, nWords);
	modport chk (input valid, isMaster, myNode, addrOffset, node, func, addr, count,
		output accept, legal, isCtrl, dbWord, bitPos, nWords);
endinterface
`default_nettype wire

//--- src/slave_request_qualifier.sv
// Purpose: qualifies a slave request and maps its address onto the database
// Assumes: coil addresses are bit addresses, sixteen coils to a word
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module slave_request_qualifier #(
	parameter int DB_DEPTH  = 32,
	parameter int MAX_WORDS = 4
) (
	// request and verdict
	req_chk_if.chk rq
);
	import ptc_pkg::*;

	localparam int DBW = $clog2(DB_DEPTH);

	logic [15:0] mapped;
	logic        coil;
	logic        funcOk;
	logic        countOk;
	logic [16:0] lastWord;

	assign mapped = rq.addr + rq.addrOffset;
	assign coil   = (rq.func == FC_COIL_ONE) || (rq.func == FC_COIL_MULTI);
	assign funcOk = isWriteFunc(rq.func) || (rq.func == FC_READ_HOLD);
	assign rq.nWords = ((rq.func == FC_COIL_ONE) || (rq.func == FC_REG_ONE)) ? 8'h01 : rq.count;
	assign countOk = (rq.nWords != 8'h00) && (rq.nWords <= 8'(MAX_WORDS));
	assign rq.bitPos = mapped[3:0];
	assign rq.dbWord = coil ? DBW'(mapped[15:4]) : DBW'(mapped);
	assign lastWord  = (coil ? {5'h00, mapped[15:4]} : {1'b0, mapped}) + {9'h000, rq.nWords};
	assign rq.isCtrl = !coil && (mapped == CTRL_ADDR);
	assign rq.accept = rq.valid && !rq.isMaster && (rq.node == rq.myNode);
	assign rq.legal  = funcOk && countOk && (rq.isCtrl || (lastWord <= 17'(DB_DEPTH)));

endmodule
`default_nettype wire

//--- src/passthrough_remote_control.sv
// Purpose: slave-port request handling, pass-through queue and remote command control
// Assumes: requests arrive parsed, one per cycle while reqReady is high
// Notes:   host reads the head block word by word, one cycle behind hostRdIdx
`timescale 1ns/1ps
`default_nettype none
module passthrough_remote_control #(
	parameter int MAX_WORDS = 4,
	parameter int Q_DEPTH   = 4,
	parameter int DB_DEPTH  = 32
) (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        srst,
	// port configuration
	input  wire logic                        portIsMaster,
	input  wire logic [7:0]                  myNode,
	input  wire logic [15:0]                 addrOffset,
	input  wire logic [1:0]                  swapCode,
	input  wire logic                        floatPass,
	// parsed slave request
	input  wire logic                        reqValid,
	input  wire logic [7:0]                  reqNode,
	input  wire logic [7:0]                  reqFunc,
	input  wire logic [15:0]                 reqAddr,
	input  wire logic [7:0]                  reqCount,
	input  wire logic [MAX_WORDS-1:0][15:0]  reqData,
	input  wire logic [MAX_WORDS-1:0][15:0]  reqMask,
	output logic                             reqReady,
	// slave response
	output logic                             respValid,
	output logic                             respExc,
	output logic [7:0]                       respNode,
	output logic [7:0]                       respFunc,
	output logic [15:0]                      respAddr,
	output logic [7:0]                       respCount,
	output logic [MAX_WORDS-1:0][15:0]       respData,
	// host block exchange
	input  wire logic [5:0]                  hostRdIdx,
	input  wire logic                        hostAckValid,
	input  wire logic [15:0]                 hostAckCode,
	output logic                             blkValid,
	output logic [15:0]                      blkWord,
	// configuration upload and restarts
	input  wire logic                        cfgDone,
	input  wire logic [1:0]                  cfgResult,
	output logic                             cfgUploadReq,
	output logic                             warmBoot,
	output logic                             coldBoot,
	// status counters and control register value
	output logic [15:0]                      cntRequests,
	output logic [15:0]                      cntResponses,
	output logic [15:0]                      ctrlValue
);
	import ptc_pkg::*;

	// ---------------------------------------------------------------
	// types and state
	// ---------------------------------------------------------------
	localparam int DBW = $clog2(DB_DEPTH);
	localparam int QW  = $clog2(Q_DEPTH);

	typedef struct packed {
		logic [15:0]                 id;
		logic [7:0]                  node;
		logic [7:0]                  func;
		logic [15:0]                 addr;
		logic [7:0]                  count;
		logic [MAX_WORDS-1:0][15:0]  data;
	} entry_s;

	typedef struct packed {
		entry_s [Q_DEPTH-1:0]            q;
		logic [QW-1:0]                   head;
		logic [QW-1:0]                   tail;
		logic [QW:0]                     used;
		logic [DB_DEPTH-1:0][15:0]       db;
		logic [15:0]                     ctrl;
		ctrl_state_e                     cs;
		logic                            reqReady;
		logic                            respValid;
		logic                            respExc;
		logic [7:0]                      respNode;
		logic [7:0]                      respFunc;
		logic [15:0]                     respAddr;
		logic [7:0]                      respCount;
		logic [MAX_WORDS-1:0][15:0]      respData;
		logic                            blkValid;
		logic [15:0]                     blkWord;
		logic                            cfgUploadReq;
		logic                            warmBoot;
		logic                            coldBoot;
		logic [15:0]                     cntRequests;
		logic [15:0]                     cntResponses;
	} state_s;

	state_s s_q;
	state_s s_d;

	// ---------------------------------------------------------------
	// request qualifier
	// ---------------------------------------------------------------
	req_chk_if #(.DBW(DBW)) rq ();

	assign rq.valid      = reqValid && s_q.reqReady;
	assign rq.isMaster   = portIsMaster;
	assign rq.myNode     = myNode;
	assign rq.addrOffset = addrOffset;
	assign rq.node       = reqNode;
	assign rq.func       = reqFunc;
	assign rq.addr       = reqAddr;
	assign rq.count      = reqCount;

	slave_request_qualifier #(
		.DB_DEPTH  (DB_DEPTH),
		.MAX_WORDS (MAX_WORDS)
	) u_qual (
		.rq (rq)
	);

	// ---------------------------------------------------------------
	// host block word selection
	// ---------------------------------------------------------------
	// block layout
	function automatic logic [15:0] blockWord(input entry_s e, input logic [5:0] idx);
		logic [5:0] di;
		di = idx - W_DATA;
		blockWord = 16'h0000;
		if (idx == W_ID) begin
			blockWord = e.id;
		end else if (idx == W_COUNT) begin
			blockWord = (e.func == FC_COIL_ONE) ? 16'h0001 : {8'h00, e.count};
		end else if (idx == W_ADDR) begin
			blockWord = e.addr;
		end else if (e.func == FC_COIL_ONE) begin
			// raw message echo after the data word
			if (idx == W_DATA) begin
				blockWord = e.data[0];
			end else if (idx == W_RAW_FIRST) begin
				blockWord = {e.node, e.func};
			end else if (idx == W_RAW_FIRST + 6'h01) begin
				blockWord = e.addr;
			end else if (idx == W_RAW_FIRST + 6'h02) begin
				blockWord = e.data[0];
			end
		end else if (idx >= W_DATA && di < 6'(MAX_WORDS) && {2'h0, di} < e.count) begin
			blockWord = e.data[di[$clog2(MAX_WORDS)-1:0]];
		end
	endfunction

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// single combinational process for the whole block
	always_comb begin
		entry_s         ent;
		logic           passMode;
		logic           toHost;
		logic           pop;
		logic           push;
		logic [DBW-1:0] idx;
		logic [15:0]    w;
		logic [15:0]    bitMask;
		ent      = '0;
		idx      = '0;
		w        = 16'h0000;
		bitMask  = 16'h0001 << rq.bitPos;
		s_d      = s_q;
		pop      = 1'b0;
		push     = 1'b0;
		s_d.respValid = 1'b0;
		s_d.warmBoot  = 1'b0;
		s_d.coldBoot  = 1'b0;
		// swap codes 2 and 3 select pass-through
		passMode = (swapCode == SWAP_PASS) || (swapCode == SWAP_PASS_BS);
		toHost   = passMode && isWriteFunc(reqFunc) && !rq.isCtrl;

		if (hostAckValid && s_q.used != '0 && hostAckCode == s_q.q[s_q.head].id) begin
			pop = 1'b1;
		end

		if (rq.accept) begin
			s_d.cntRequests  = s_q.cntRequests + 16'h0001;
			s_d.cntResponses = s_q.cntResponses + 16'h0001;
			s_d.respValid = 1'b1;
			s_d.respExc   = !rq.legal;
			s_d.respNode  = reqNode;
			s_d.respFunc  = reqFunc;
			s_d.respAddr  = reqAddr;
			s_d.respCount = reqCount;
			s_d.respData  = '0;
			if (rq.legal && rq.isCtrl) begin
				if (reqFunc == FC_READ_HOLD) begin
					s_d.respData[0] = s_q.ctrl;
				end else if (s_q.cs == CS_IDLE) begin
					unique case (reqData[0])
						CMD_UPLOAD: begin
							s_d.ctrl         = CMD_UPLOAD;
							s_d.cs           = CS_UPLOAD;
							s_d.cfgUploadReq = 1'b1;
						end
						CMD_WARM: begin
							s_d.ctrl     = CTRL_RESET;
							s_d.warmBoot = 1'b1;
						end
						CMD_COLD: begin
							s_d.ctrl     = CTRL_RESET;
							s_d.coldBoot = 1'b1;
						end
						default: begin
							s_d.ctrl = s_q.ctrl;
						end
					endcase
				end
			end else if (rq.legal && toHost) begin
				push      = 1'b1;
				ent.node  = reqNode;
				ent.func  = reqFunc;
				ent.count = rq.nWords;
				unique case (reqFunc)
					FC_COIL_ONE:   ent.id = ID_COIL_ONE;
					FC_COIL_MULTI: ent.id = ID_COIL_MULTI;
					default:       ent.id = floatPass ? ID_REG_FLOAT : ID_REG_INT;
				endcase
				ent.addr = (reqFunc == FC_COIL_MULTI) ? {{(16-DBW){1'b0}}, rq.dbWord} :
					reqAddr + addrOffset;
				for (int i = 0; i < MAX_WORDS; i++) begin
					idx = rq.dbWord + DBW'(i);
					w = (swapCode == SWAP_PASS_BS) ? swapBytes(reqData[i]) : reqData[i];
					ent.data[i] = (reqFunc == FC_COIL_MULTI) ?
						mergeBits(s_q.db[idx], w, reqMask[i]) : w;
				end
			end else if (rq.legal) begin
				for (int i = 0; i < MAX_WORDS; i++) begin
					idx = rq.dbWord + DBW'(i);
					if (8'(i) < rq.nWords) begin
						unique case (reqFunc)
							FC_READ_HOLD:  s_d.respData[i] = s_q.db[idx];
							FC_COIL_ONE:   s_d.db[idx] = mergeBits(s_q.db[idx],
								(reqData[0] != 16'h0000) ? 16'hFFFF : 16'h0000, bitMask);
							FC_COIL_MULTI: s_d.db[idx] = mergeBits(s_q.db[idx], reqData[i],
								reqMask[i]);
							default:       s_d.db[idx] = reqData[i];
						endcase
					end
				end
			end
		end

		if (s_q.cs == CS_UPLOAD && cfgDone) begin
			unique case (cfgResult)
				2'h0: s_d.ctrl = RES_OK;
				2'h1: s_d.ctrl = RES_GENERAL;
				2'h2: s_d.ctrl = RES_PORT1;
				2'h3: s_d.ctrl = RES_PORT2;
			endcase
			s_d.cs           = CS_IDLE;
			s_d.cfgUploadReq = 1'b0;
			s_d.warmBoot     = 1'b1;
		end

		// queue pointer bookkeeping
		if (push) begin
			s_d.q[s_q.tail] = ent;
			s_d.tail        = s_q.tail + QW'(1);
		end
		if (pop) begin
			s_d.head = s_q.head + QW'(1);
		end
		s_d.used     = s_q.used + (QW+1)'(push) - (QW+1)'(pop);
		s_d.reqReady = s_d.used != (QW+1)'(Q_DEPTH);
		// only the head block is shown
		s_d.blkValid = s_d.used != '0;
		s_d.blkWord  = s_d.blkValid ? blockWord(s_d.q[s_d.head], hostRdIdx) : 16'h0000;
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	// synchronous reset of every field
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_q          <= '0;
			s_q.ctrl     <= CTRL_RESET;
			s_q.cs       <= CS_IDLE;
			s_q.reqReady <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign reqReady     = s_q.reqReady;
	assign respValid    = s_q.respValid;
	assign respExc      = s_q.respExc;
	assign respNode     = s_q.respNode;
	assign respFunc     = s_q.respFunc;
	assign respAddr     = s_q.respAddr;
	assign respCount    = s_q.respCount;
	assign respData     = s_q.respData;
	assign blkValid     = s_q.blkValid;
	assign blkWord      = s_q.blkWord;
	assign cfgUploadReq = s_q.cfgUploadReq;
	assign warmBoot     = s_q.warmBoot;
	assign coldBoot     = s_q.coldBoot;
	assign cntRequests  = s_q.cntRequests;
	assign cntResponses = s_q.cntResponses;
	assign ctrlValue    = s_q.ctrl;

endmodule
`default_nettype wire

//--- verif/passthrough_remote_control_sva.sv
// Purpose: port-level checks for the pass-through and remote control block
// Assumes: one clock, synchronous active-high reset
// Notes:   attached to the top module by bind
`timescale 1ns/1ps
`default_nettype none
module passthrough_remote_control_sva (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        srst,
	// slave request and response
	input wire logic        portIsMaster,
	input wire logic [7:0]  myNode,
	input wire logic        reqValid,
	input wire logic [7:0]  reqNode,
	input wire logic [7:0]  reqFunc,
	input wire logic [15:0] reqAddr,
	input wire logic        reqReady,
	input wire logic        respValid,
	input wire logic [7:0]  respNode,
	input wire logic [7:0]  respFunc,
	input wire logic [15:0] respAddr,
	input wire logic [15:0] cntRequests,
	// host side and control
	input wire logic        hostAckValid,
	input wire logic        blkValid,
	input wire logic        cfgDone,
	input wire logic [1:0]  cfgResult,
	input wire logic        cfgUploadReq,
	input wire logic        warmBoot,
	input wire logic        coldBoot,
	input wire logic [15:0] ctrlValue
);
	logic taken;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	// -------------------------------------------------------------
	// slave requests
	// -------------------------------------------------------------
	// request accepted this cycle
	assign taken = reqValid && reqReady && !portIsMaster && (reqNode == myNode);
	AST_RESP_NEXT: assert property (taken |=> respValid)
		else $error("response missing");
	AST_NO_SPURIOUS: assert property (!taken |=> !respValid)
		else $error("spurious response");
	AST_RESP_ECHO: assert property (taken |=> respNode == $past(reqNode)
		&& respFunc == $past(reqFunc) && respAddr == $past(reqAddr))
		else $error("bad echo");
	AST_REQ_COUNT: assert property (taken |=> cntRequests == $past(cntRequests) + 16'h0001)
		else $error("request counter did not step");

	// -------------------------------------------------------------
	// remote command control
	// -------------------------------------------------------------
	// cold boot clears
	AST_COLD_CLEAR: assert property (coldBoot |-> ctrlValue == 16'h0000)
		else $error("ctrl not cleared");
	AST_WARM_CODE: assert property (warmBoot |->
		ctrlValue inside {16'h0000, 16'hFFFF, 16'hFFFE, 16'hFFFD})
		else $error("bad control value at warm boot");
	AST_UPLOAD_END: assert property (cfgUploadReq && cfgDone |=> !cfgUploadReq && warmBoot
		&& ctrlValue == 16'h0000 - {14'h0000, $past(cfgResult)})
		else $error("upload end wrong");
	AST_UPLOAD_HOLD: assert property (cfgUploadReq && !cfgDone |=>
		cfgUploadReq && $stable(ctrlValue))
		else $error("upload disturbed");

	// -------------------------------------------------------------
	// host blocks
	// -------------------------------------------------------------
	// block stays until acknowledged
	AST_BLK_HOLD: assert property (blkValid && !hostAckValid |=> blkValid)
		else $error("block withdrawn");
	AST_READY_EMPTY: assert property (!blkValid |-> reqReady)
		else $error("not ready with empty queue");
endmodule

bind passthrough_remote_control passthrough_remote_control_sva i_sva (.*);
`default_nettype wire

//--- verif/host_block_model.sv
// Purpose: host model that reads, acknowledges blocks and finishes uploads
// Assumes: blkWord follows hostRdIdx one cycle later
// Notes:   slow stretches the time before each acknowledgement
`timescale 1ns/1ps
`default_nettype none
module host_block_model (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// bench controls
	input  wire logic        slow,
	input  wire logic [1:0]  resSel,
	output logic             gotBlk,
	output logic [7:0][15:0] seen,
	// block exchange
	input  wire logic        blkValid,
	input  wire logic [15:0] blkWord,
	output logic [5:0]       hostRdIdx,
	output logic             hostAckValid,
	output logic [15:0]      hostAckCode,
	// configuration upload
	input  wire logic        cfgUploadReq,
	output logic             cfgDone,
	output logic [1:0]       cfgResult
);
	logic [5:0] s;
	logic [2:0] up;

	// -------------------------------------------------------------
	// block reader and upload responder
	// -------------------------------------------------------------
	// released lines carry a changing pattern
	always_ff @(posedge sys_clk) begin
		hostAckValid <= 1'b0;
		gotBlk       <= 1'b0;
		cfgDone      <= 1'b0;
		hostAckCode  <= ~hostAckCode;
		cfgResult    <= ~cfgResult;
		if (srst) begin
			s           <= 6'h00;
			up          <= 3'h0;
			hostRdIdx   <= 6'h00;
			hostAckCode <= 16'h0000;
			cfgResult   <= 2'h0;
		end else begin
			if (s != 6'h00 || (blkValid && !hostAckValid)) begin
				s <= s + 6'h01;
			end
			if (s < 6'h08) begin
				hostRdIdx <= s;
			end
			if (s >= 6'h02 && s < 6'h0A) begin
				seen[s - 6'h02] <= blkWord;
			end
			if (s == (slow ? 6'h18 : 6'h0C)) begin
				hostAckValid <= 1'b1;
				hostAckCode  <= seen[1];
				gotBlk       <= 1'b1;
				s            <= 6'h00;
			end
			up <= (cfgUploadReq && !cfgDone) ? up + 3'h1 : 3'h0;
			if (up == 3'h3) begin
				cfgDone   <= 1'b1;
				cfgResult <= resSel;
				up        <= 3'h0;
			end
		end
	end
endmodule
`default_nettype wire

//--- verif/test_passthrough_remote_control.sv
// Purpose: self-checking bench for the pass-through and remote control block
// Assumes: host side played by host_block_model
// Notes:   database and block contents predicted by the bench
`timescale 1ns/1ps
`default_nettype none
module test_passthrough_remote_control;
	import ptc_pkg::*;
	logic             sys_clk, srst, portIsMaster, floatPass, reqValid, slow, reqReady;
	logic             respValid, respExc, hostAckValid, blkValid, cfgDone, cfgUploadReq;
	logic             warmBoot, coldBoot, gotBlk;
	logic [7:0]       myNode, reqNode, reqFunc, reqCount, respNode, respFunc, respCount, fc;
	logic [15:0]      addrOffset, reqAddr, respAddr, hostAckCode, blkWord, ia;
	logic [15:0]      cntRequests, cntResponses, ctrlValue;
	logic [1:0]       swapCode, cfgResult, resSel;
	logic [5:0]       hostRdIdx;
	logic [3:0][15:0] reqData, reqMask, respData, dIn, mIn;
	logic [7:0][15:0] seen, e;
	logic [7:0][15:0] expQ[$];
	logic [15:0]      dbm[0:31];
	logic [31:0]      rng;
	int               failCount, nChecks, nResp, nWarm, nCold, cnt, w0;

	passthrough_remote_control i_dut (.*);
	host_block_model i_host (.*);

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic logic [15:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[15:0];
	endfunction

	task automatic chk(input string what, input logic [15:0] seenV, input logic [15:0] expV);
		nChecks++;
		if (seenV !== expV) begin
			failCount++;
			$display("mismatch %s expected %h seen %h", what, expV, seenV);
		end
	endtask

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// one request at internal address ia, held until taken, or for one cycle when no response is expected
	task automatic req(input logic [7:0] nd, f, input logic ms, expResp, expExc);
		@(posedge sys_clk);
		reqValid     <= 1'b1;
		portIsMaster <= ms;
		reqNode      <= nd;
		reqFunc      <= f;
		reqAddr      <= ia - addrOffset;
		reqCount     <= 8'(cnt);
		reqData      <= dIn;
		reqMask      <= mIn;
		for (int w = 0; w < 300; w++) begin
			@(posedge sys_clk);
			if (reqReady || !expResp) break;
		end
		reqValid     <= 1'b0;
		portIsMaster <= 1'b0;
		#1;
		chk("respValid", 16'(respValid), 16'(expResp));
		if (expResp) begin
			nResp++;
			chk("respExc", 16'(respExc), 16'(expExc));
			chk("respAddr", respAddr, ia - addrOffset);
			chk("respCount", 16'(respCount), 16'(cnt));
		end
	endtask

	// -------------------------------------------------------------
	// clock, monitors and watchdog
	// -------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// boot pulse counts and block comparison
	always @(posedge sys_clk) begin
		if (warmBoot === 1'b1) nWarm++;
		if (coldBoot === 1'b1) nCold++;
		if (gotBlk === 1'b1) begin
			e = expQ.pop_front();
			for (int k = 0; k < 8; k++) begin
				chk("blkWord", seen[k], e[k]);
			end
		end
	end

	// run needs about 300 cycles
	initial begin
		repeat (30000) @(posedge sys_clk);
		failCount++;
		giveVerdict();
	end

	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		rng = 32'h0000001A;
		{srst, portIsMaster, floatPass, reqValid, slow} = 5'b10000;
		{myNode, addrOffset, swapCode, resSel} = {8'h11, 16'h0004, 2'h0, 2'h0};
		{reqNode, reqFunc, reqAddr, reqCount, reqData, reqMask} = '0;
		{dIn, mIn} = '0;
		repeat (4) @(posedge sys_clk);
		#1;
		chk("reqReady", 16'(reqReady), 16'h0001);
		chk("ctrlValue", ctrlValue, 16'h0000);
		@(posedge sys_clk);
		srst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			cnt = (i == 6) ? 4 : 1 + rnd() % 4;
			ia = (i == 6) ? 16'h0008 : 16'(rnd() % (33 - cnt));
			for (int k = 0; k < 4; k++) begin
				dIn[k] = rnd();
			end
			req(myNode, (cnt == 1) ? FC_REG_ONE : FC_REG_MULTI, 1'b0, 1'b1, 1'b0);
			for (int k = 0; k < cnt; k++) begin
				dbm[ia + k] = dIn[k];
			end
			req(myNode, FC_READ_HOLD, 1'b0, 1'b1, 1'b0);
			for (int k = 0; k < cnt; k++) begin
				chk("respData", respData[k], dbm[ia + k]);
			end
		end
		// foreign node, master mode, illegal requests
		req(8'h12, FC_REG_ONE, 1'b0, 1'b0, 1'b0);
		req(myNode, FC_REG_ONE, 1'b1, 1'b0, 1'b0);
		req(myNode, 8'h07, 1'b0, 1'b1, 1'b1);
		ia = 16'h001F;
		cnt = 2;
		req(myNode, FC_REG_MULTI, 1'b0, 1'b1, 1'b1);
		@(posedge sys_clk);
		#1;
		chk("cntResponses", cntResponses, 16'(nResp));
		$display("test local done");
		cnt = 1;
		for (int r = 0; r < 4; r++) begin
			resSel = 2'(r);
			w0 = nWarm;
			ia = CTRL_ADDR;
			dIn[0] = CMD_UPLOAD;
			req(myNode, FC_REG_ONE, 1'b0, 1'b1, 1'b0);
			chk("cfgUploadReq", 16'(cfgUploadReq), 16'h0001);
			for (int w = 0; w < 50 && cfgUploadReq !== 1'b0; w++) @(posedge sys_clk);
			#1;
			chk("ctrlValue", ctrlValue, 16'h0000 - 16'(r));
			chk("warmBoots", 16'(nWarm), 16'(w0 + 1));
			dIn[0] = 16'h1234;
			req(myNode, FC_REG_ONE, 1'b0, 1'b1, 1'b0);
			req(myNode, FC_READ_HOLD, 1'b0, 1'b1, 1'b0);
			chk("ctrlRead", respData[0], 16'h0000 - 16'(r));
		end
		w0 = nWarm;
		for (int b = 0; b < 2; b++) begin
			dIn[0] = b ? CMD_WARM : CMD_COLD;
			req(myNode, FC_REG_ONE, 1'b0, 1'b1, 1'b0);
			repeat (2) @(posedge sys_clk);
			#1;
			chk("ctrlValue", ctrlValue, 16'h0000);
			chk("coldBoots", 16'(nCold), 16'h0001);
			chk("warmBoots", 16'(nWarm), 16'(w0 + b));
		end
		$display("test control done");
		// five writes queue behind a slow host
		@(posedge sys_clk);
		swapCode <= SWAP_PASS;
		slow <= 1'b1;
		for (int j = 0; j < 5; j++) begin
			for (int k = 0; k < 4; k++) begin
				dIn[k] = rnd();
				mIn[k] = rnd();
			end
			cnt = (j < 2) ? 1 : (j == 2) ? 4 : 2;
			ia = (j == 0) ? 16'(rnd() % 512) : (j == 3) ? 16'h0080 : 16'(rnd() % 29);
			dIn[0] = (j == 0) ? 16'hFF00 : dIn[0];
			fc = (j == 0) ? FC_COIL_ONE : (j == 1) ? FC_REG_ONE :
				(j == 3) ? FC_COIL_MULTI : FC_REG_MULTI;
			e = '0;
			e[1] = (j == 0) ? ID_COIL_ONE : (j == 3) ? ID_COIL_MULTI :
				(j == 2) ? ID_REG_FLOAT : ID_REG_INT;
			e[2] = 16'(cnt);
			e[3] = (j == 3) ? (ia >> 4) : ia;
			for (int k = 0; k < cnt; k++) begin
				e[4 + k] = (j == 3) ? ((dbm[8 + k] & ~mIn[k]) | (dIn[k] & mIn[k])) :
					(j == 4) ? {dIn[k][7:0], dIn[k][15:8]} : dIn[k];
			end
			if (j == 0) e[7:5] = {dIn[0], ia, myNode, FC_COIL_ONE};
			expQ.push_back(e);
			@(posedge sys_clk);
			floatPass <= (j == 2);
			swapCode <= (j == 4) ? SWAP_PASS_BS : SWAP_PASS;
			req(myNode, fc, 1'b0, 1'b1, 1'b0);
		end
		for (int w = 0; w < 400 && (expQ.size() > 0 || blkValid); w++) @(posedge sys_clk);
		#1;
		chk("blocksLeft", 16'(expQ.size()), 16'h0000);
		chk("blkValid", 16'(blkValid), 16'h0000);
		@(posedge sys_clk);
		swapCode <= 2'h0;
		ia = 16'h0008;
		cnt = 4;
		req(myNode, FC_READ_HOLD, 1'b0, 1'b1, 1'b0);
		for (int k = 0; k < 4; k++) begin
			chk("respData", respData[k], dbm[8 + k]);
		end
		$display("test pass-through done");
		giveVerdict();
	end
endmodule
`default_nettype wire
